// ---- shared/smc_pkg.sv ----
// Shared constants and types for the serial port core
package smc_pkg;
  // Baud-rate generator divisor reset value and width
  localparam int BRG_W = 16;
  localparam logic [15:0] BRG_RESET = 16'h0002;
  localparam logic [15:0] BRG_RELOAD_AT = 16'h0001;
  // Status bit positions
  localparam int ST_DONE_POS = 7;
  localparam int ST_WRITE_COLLISION_FLAG_POS = 6;
  localparam int ST_MODE_FAULT_FLAG_POS = 4;
  // Byte length
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] EDGE_COUNT = 4'h8;
  // Receive FIFO depth
  localparam int FIFO_DEPTH = 8;
  // Transfer state encoding
  typedef enum logic [1:0] {
    SMC_IDLE = 2'b00,
    SMC_MXFER = 2'b01,
    SMC_SXFER = 2'b10
  } smc_state_t;
endpackage

// ---- design/smc_fifo.sv ----
// Receive FIFO with valid/ready on both sides
`timescale 1ns/1ps
module smc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Elaboration check: pointers need a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];  // Storage
  logic [AW:0] wp_r;  // Write pointer
  logic [AW:0] rp_r;  // Read pointer
  wire logic full_w = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire logic empty_w = (wp_r == rp_r);
  wire logic push_w = in_valid && !full_w;
  wire logic pop_w = out_ready && !empty_w;
  assign in_ready = !full_w;
  assign out_valid = !empty_w;
  assign out_data = mem_r[rp_r[AW-1:0]];
  // Pointer and storage update
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push_w) begin
        mem_r[wp_r[AW-1:0]] <= in_data;
        wp_r <= wp_r + 1'b1;
      end
      if (pop_w) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

// ---- design/smc_core.sv ----
// Full-duplex byte serial port, master or slave
`timescale 1ns/1ps
module smc_core
  import smc_pkg::*;
#(
  parameter int RX_DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  // Control writes
  input wire logic CTL_WR_IN,
  input wire logic CTL_EN_IN,
  input wire logic CTL_MASTER_IN,
  input wire logic CTL_POL_IN,
  input wire logic CTL_PHASE_IN,
  input wire logic BRG_WR_IN,
  input wire logic [15:0] BRG_DIV_IN,
  // Transmit write
  input wire logic TX_WR_IN,
  input wire logic [7:0] TX_DATA_IN,
  // Status read
  input wire logic STATUS_RD_IN,
  output logic [7:0] STATUS_OUT,
  output logic EN_OUT,
  output logic MASTER_OUT,
  output logic BUSY_OUT,
  // Receive stream
  output logic RX_VALID_OUT,
  input wire logic RX_READY_IN,
  output logic [7:0] RX_DATA_OUT,
  // Serial pins
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE_OUT,
  input wire logic SS_N_IN,
  input wire logic MISO_IN,
  output logic MISO_OUT,
  output logic MISO_OE_OUT,
  input wire logic MOSI_IN,
  output logic MOSI_OUT,
  output logic MOSI_OE_OUT
);
  // Elaboration check on the queue depth
  if (RX_DEPTH < 2) begin : g_bad_depth
    $error("RX_DEPTH too small");
  end

  // Control and status registers
  logic en_r, master_r, pol_r, pha_r;
  logic done_r, write_collision_flag_r, mode_fault_flag_r;
  logic [15:0] div_r;  // Divisor latch
  logic [15:0] cnt_r;  // Baud down counter
  logic tick_r;  // End-of-count pulse
  smc_state_t st_r;
  logic [7:0] sh_r;  // Shift register
  logic [3:0] bits_r;  // Sampled bit count
  logic sck_r;  // Master clock level
  logic half_r;  // Divide-by-two phase
  logic out_bit_r;  // Current serial output bit
  logic [7:0] sample_r;  // Sample holder for master and slave
  // Synchronisers for the serial input pins, including MISO for the master
  logic sck_m_r, sck_s_r, sck_d_r;
  logic ss_m_r, ss_s_r, ss_d_r;
  logic mosi_m_r, mosi_s_r;
  logic miso_m_r, miso_s_r;

  // Receive FIFO hookup
  logic rx_push_r;
  logic [7:0] rx_byte_r;
  wire logic rx_ready_w;

  // Named decode wires
  wire logic busy_w = (st_r != SMC_IDLE);
  wire logic is_master_w = en_r && master_r;
  wire logic is_slave_w = en_r && !master_r;
  // Effective slave shift clock: select ORed with clock in phase 0
  wire logic eff_sck_w = pha_r ? sck_s_r : (sck_s_r | ss_s_r);
  wire logic eff_sck_d_w = pha_r ? sck_d_r : (sck_d_r | ss_d_r);
  wire logic s_rise_w = eff_sck_w && !eff_sck_d_w;
  wire logic s_fall_w = !eff_sck_w && eff_sck_d_w;
  // Receive edge is rising when phase equals polarity
  wire logic rx_on_rise_w = (pha_r == pol_r);
  wire logic s_rx_edge_w = rx_on_rise_w ? s_rise_w : s_fall_w;
  wire logic s_tx_edge_w = rx_on_rise_w ? s_fall_w : s_rise_w;
  wire logic ss_fall_w = !ss_s_r && ss_d_r;
  wire logic ss_rise_w = ss_s_r && !ss_d_r;
  wire logic fault_w = is_master_w && !ss_s_r;
  wire logic tx_accept_w = TX_WR_IN && !busy_w;
  wire logic collide_w = TX_WR_IN && busy_w;
  wire logic ser_in_w = master_r ? miso_s_r : mosi_s_r;
  // Master: receive half is the toggle leaving idle level in phase 0
  wire logic m_lead_w = tick_r && (sck_r == pol_r);
  wire logic m_trail_w = tick_r && (sck_r != pol_r);
  wire logic m_sample_w = pha_r ? m_trail_w : m_lead_w;
  wire logic m_shift_w = pha_r ? m_lead_w : m_trail_w;
  wire logic byte_end_w = (bits_r == EDGE_COUNT);
  // Master byte ends on the trail after eight samples; phase 1 samples on it
  wire logic m_last_w = pha_r ? (bits_r == EDGE_COUNT - 4'h1) : byte_end_w;
  wire logic m_end_w = m_trail_w && m_last_w;
  // Finished byte; in phase 1 it includes the sample taken on the ending edge
  wire logic [7:0] m_rx_byte_w = pha_r ? {sh_r[6:0], ser_in_w} : sample_r;

  // Baud-rate generator down counter
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      div_r <= BRG_RESET;
      cnt_r <= BRG_RESET;
      tick_r <= 1'b0;
    end else if (BRG_WR_IN) begin
      div_r <= BRG_DIV_IN;
      cnt_r <= BRG_DIV_IN;
      tick_r <= 1'b0;
    end else if (cnt_r == BRG_RELOAD_AT) begin
      cnt_r <= div_r;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r - 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // Pin synchronisers
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      sck_m_r <= 1'b0;
      sck_s_r <= 1'b0;
      sck_d_r <= 1'b0;
      ss_m_r <= 1'b1;
      ss_s_r <= 1'b1;
      ss_d_r <= 1'b1;
      mosi_m_r <= 1'b0;
      mosi_s_r <= 1'b0;
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
    end else begin
      sck_m_r <= SCK_IN;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
      ss_m_r <= SS_N_IN;
      ss_s_r <= ss_m_r;
      ss_d_r <= ss_s_r;
      mosi_m_r <= MOSI_IN;
      mosi_s_r <= mosi_m_r;
      miso_m_r <= MISO_IN;
      miso_s_r <= miso_m_r;
    end
  end

  // Control bits; mode fault drops enable and master
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      en_r <= 1'b0;
      master_r <= 1'b0;
      pol_r <= 1'b0;
      pha_r <= 1'b1;
    end else if (fault_w) begin
      en_r <= 1'b0;
      master_r <= 1'b0;
    end else if (CTL_WR_IN) begin
      en_r <= CTL_EN_IN;
      master_r <= CTL_MASTER_IN;
      pol_r <= CTL_POL_IN;
      pha_r <= CTL_PHASE_IN;
    end
  end

  // Status flags: set wins over read clear
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
    end else begin
      done_r <= rx_push_r | (done_r & !STATUS_RD_IN);
      write_collision_flag_r <= collide_w | (write_collision_flag_r & !STATUS_RD_IN);
      mode_fault_flag_r <= fault_w | (mode_fault_flag_r & !STATUS_RD_IN);
    end
  end

  // Transfer engine for both roles
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      st_r <= SMC_IDLE;
      sh_r <= 8'h00;
      bits_r <= 4'h0;
      sck_r <= 1'b0;
      half_r <= 1'b0;
      out_bit_r <= 1'b0;
      rx_push_r <= 1'b0;
      rx_byte_r <= 8'h00;
      sample_r <= 8'h00;
    end else begin
      rx_push_r <= 1'b0;
      unique case (st_r)
        SMC_IDLE: begin
          // Idle clock at polarity level
          sck_r <= pol_r;
          half_r <= 1'b0;
          bits_r <= 4'h0;
          if (tx_accept_w) begin
            sh_r <= TX_DATA_IN;
            out_bit_r <= TX_DATA_IN[7];
          end
          if (tx_accept_w && is_master_w) begin
            st_r <= SMC_MXFER;
          end else if (is_slave_w && !ss_s_r && (pha_r ? s_tx_edge_w : ss_fall_w)) begin
            // Phase 0 starts on select fall, phase 1 at first edge
            st_r <= SMC_SXFER;
            out_bit_r <= sh_r[7];
          end else if (is_slave_w && !ss_s_r && pha_r && s_rx_edge_w) begin
            st_r <= SMC_SXFER;
            sample_r <= {sh_r[6:0], ser_in_w};
            bits_r <= 4'h1;
          end
        end
        SMC_MXFER: begin
          // Divide baud ticks by two to form the clock
          if (tick_r) begin
            sck_r <= !sck_r;
            half_r <= !half_r;
          end
          if (m_sample_w) begin
            sample_r <= {sh_r[6:0], ser_in_w};
            bits_r <= bits_r + 4'h1;
          end
          if (m_shift_w && bits_r != 4'h0) begin
            sh_r <= sample_r;
            out_bit_r <= sample_r[7];
          end
          if (m_end_w) begin
            st_r <= SMC_IDLE;
            rx_byte_r <= m_rx_byte_w;
            sh_r <= m_rx_byte_w;
            rx_push_r <= 1'b1;
          end
          if (!is_master_w) begin
            st_r <= SMC_IDLE;
          end
        end
        SMC_SXFER: begin
          if (s_rx_edge_w && !ss_s_r) begin
            sample_r <= {sh_r[6:0], ser_in_w};
            bits_r <= bits_r + 4'h1;
          end
          if (s_tx_edge_w && !ss_s_r && bits_r != 4'h0 && !byte_end_w) begin
            sh_r <= sample_r;
            out_bit_r <= sample_r[7];
          end
          if (byte_end_w && (pha_r || ss_rise_w)) begin
            // Phase 1 ends at completion, phase 0 on select rise
            st_r <= SMC_IDLE;
            sh_r <= sample_r;
            rx_byte_r <= sample_r;
            rx_push_r <= 1'b1;
          end else if (ss_rise_w && !pha_r) begin
            st_r <= SMC_IDLE;  // Aborted frame
          end
          if (!is_slave_w) begin
            st_r <= SMC_IDLE;
          end
        end
        default: st_r <= SMC_IDLE;
      endcase
    end
  end

  // Registered outputs and pin drivers
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      STATUS_OUT <= 8'h00;
      EN_OUT <= 1'b0;
      MASTER_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
      SCK_OUT <= 1'b0;
      SCK_OE_OUT <= 1'b0;
      MISO_OUT <= 1'b0;
      MISO_OE_OUT <= 1'b0;
      MOSI_OUT <= 1'b0;
      MOSI_OE_OUT <= 1'b0;
    end else begin
      STATUS_OUT <= 8'h00;
      STATUS_OUT[ST_DONE_POS] <= done_r;
      STATUS_OUT[ST_WRITE_COLLISION_FLAG_POS] <= write_collision_flag_r;
      STATUS_OUT[ST_MODE_FAULT_FLAG_POS] <= mode_fault_flag_r;
      EN_OUT <= en_r;
      MASTER_OUT <= master_r;
      BUSY_OUT <= busy_w;
      SCK_OUT <= is_master_w ? sck_r : pol_r;
      SCK_OE_OUT <= is_master_w;
      MOSI_OUT <= out_bit_r;
      MOSI_OE_OUT <= is_master_w;
      MISO_OUT <= out_bit_r;
      MISO_OE_OUT <= is_slave_w && !ss_s_r;
    end
  end

  // Received bytes queue for the reader
  smc_fifo #(.WIDTH(BYTE_BITS), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .CLK_IN(CLK_IN),
    .SRST_IN(SRST_IN),
    .in_valid(rx_push_r),
    .in_ready(rx_ready_w),
    .in_data(rx_byte_r),
    .out_valid(RX_VALID_OUT),
    .out_ready(RX_READY_IN),
    .out_data(RX_DATA_OUT)
  );

  // Master clock toggles within the current byte
  logic [4:0] m_edges_r;
  // Counter cleared outside master transfers
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || st_r != SMC_MXFER) begin
      m_edges_r <= 5'h00;
    end else if (tick_r) begin
      m_edges_r <= m_edges_r + 5'h01;
    end
  end

  // Checks on the logic above
  chk_master_edges: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    (rx_push_r && master_r) |-> m_edges_r == 5'(2 * BYTE_BITS)) else $error("edge count");
  chk_fault_clears_en: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    fault_w |=> !en_r && !master_r && mode_fault_flag_r) else $error("fault did not disable");
  chk_write_collision_flag_on_busy_wr: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    (TX_WR_IN && busy_w) |=> write_collision_flag_r) else $error("no write_collision_flag");
  chk_miso_float_sel: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    ss_s_r |=> !MISO_OE_OUT) else $error("miso driven unselected");
  chk_disabled_float: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    !en_r |=> !MISO_OE_OUT && !MOSI_OE_OUT) else $error("pins driven disabled");
  chk_master_dirs: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    is_master_w |=> MOSI_OE_OUT && !MISO_OE_OUT) else $error("master direction");
  chk_done_on_push: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    rx_push_r |=> done_r) else $error("done not set");
  chk_read_clears: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    (STATUS_RD_IN && !rx_push_r && !collide_w && !fault_w) |=> !done_r && !write_collision_flag_r && !mode_fault_flag_r)
    else $error("read did not clear");
  chk_byte_eight: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    rx_push_r |-> bits_r == EDGE_COUNT) else $error("byte not eight bits");
  chk_brg_reload: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    (cnt_r == BRG_RELOAD_AT && !BRG_WR_IN) |=> tick_r && cnt_r == div_r)
    else $error("brg reload");
  chk_idle_clock: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    (st_r == SMC_IDLE && !CTL_WR_IN) [*2] |=> SCK_OUT == pol_r) else $error("clock idle");
  cov_master_byte: cover property (@(posedge CLK_IN) st_r == SMC_MXFER ##[1:300] rx_push_r);
  cov_slave_byte: cover property (@(posedge CLK_IN) st_r == SMC_SXFER ##[1:1000] rx_push_r);
  cov_slave_hold: cover property (@(posedge CLK_IN) rx_push_r && pha_r && !ss_s_r);
  cov_fault: cover property (@(posedge CLK_IN) fault_w);
  cov_collide: cover property (@(posedge CLK_IN) collide_w);
endmodule

// ---- testbench/smc_partner.sv ----
// Behavioural external slave seen by the core in master mode
`timescale 1ns/1ps
module smc_partner (
  // Serial pins
  input wire logic sck_in,
  input wire logic sel_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  // Mode and data
  input wire logic pol_in,
  input wire logic pha_in,
  input wire logic [7:0] tx_in,
  output logic [7:0] rx_out,
  output int edges_out
);
  logic [7:0] sh_r = 8'h00; // Outgoing byte
  logic first_r = 1'b1; // Skips shift on first drive edge in phase 1
  logic lead; // Edge leaves the idle level
  // Load byte when selected
  always @(negedge sel_n_in) begin
    sh_r = tx_in;
    first_r = 1'b1;
    edges_out = 0;
  end
  // Released line shows the inverse of the last bit
  assign miso_out = sel_n_in ? ~sh_r[7] : sh_r[7];
  // Sample on receive edge, shift on transmit edge
  always @(sck_in) begin
    if (!sel_n_in) begin
      lead = (sck_in !== pol_in);
      edges_out = edges_out + 1;
      if (lead != pha_in) begin
        rx_out = {rx_out[6:0], mosi_in};
      end else begin
        if (!(pha_in && first_r)) sh_r = {sh_r[6:0], 1'b0};
        first_r = 1'b0;
      end
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the serial port core
`timescale 1ns/1ps
module tb_top;
  import smc_pkg::*;
  localparam int DIV = 4; // Baud divisor under test
  localparam int HP = 16; // Half period of bench-made slave clock
  logic clk = 1'b0, srst = 1'b1, ctl_wr = 1'b0, en = 1'b0, mst = 1'b0;
  logic pol = 1'b0, pha = 1'b1, brg_wr = 1'b0, tx_wr = 1'b0, st_rd = 1'b0;
  logic rx_rdy = 1'b0, sck_tb = 1'b0, ss_n = 1'b1, mosi_tb = 1'b0, psel_n = 1'b1;
  logic [15:0] div = 16'h0004;
  logic [7:0] txd = 8'h00, ptx = 8'h00, status, rxd, prx;
  logic en_o, mst_o, busy, rxv, sck_o, sck_oe, miso_o, miso_oe, mosi_o, mosi_oe;
  logic p_miso;
  int pedges;
  int err_count = 0;
  int tests_run = 0;
  logic [7:0] exp_q[$]; // Bytes the receive stream should deliver
  // Resolved pin levels
  wire sck_w = sck_oe ? sck_o : sck_tb;
  wire mosi_w = mosi_oe ? mosi_o : mosi_tb;
  wire miso_w = miso_oe ? miso_o : p_miso;
  smc_core i_dut (
    .CLK_IN(clk), .SRST_IN(srst), .CTL_WR_IN(ctl_wr), .CTL_EN_IN(en),
    .CTL_MASTER_IN(mst), .CTL_POL_IN(pol), .CTL_PHASE_IN(pha),
    .BRG_WR_IN(brg_wr), .BRG_DIV_IN(div), .TX_WR_IN(tx_wr), .TX_DATA_IN(txd),
    .STATUS_RD_IN(st_rd), .STATUS_OUT(status), .EN_OUT(en_o), .MASTER_OUT(mst_o),
    .BUSY_OUT(busy), .RX_VALID_OUT(rxv), .RX_READY_IN(rx_rdy), .RX_DATA_OUT(rxd),
    .SCK_IN(sck_w), .SCK_OUT(sck_o), .SCK_OE_OUT(sck_oe), .SS_N_IN(ss_n),
    .MISO_IN(miso_w), .MISO_OUT(miso_o), .MISO_OE_OUT(miso_oe),
    .MOSI_IN(mosi_w), .MOSI_OUT(mosi_o), .MOSI_OE_OUT(mosi_oe)
  );
  smc_partner i_partner (
    .sck_in(sck_w), .sel_n_in(psel_n), .mosi_in(mosi_w), .miso_out(p_miso),
    .pol_in(pol), .pha_in(pha), .tx_in(ptx), .rx_out(prx), .edges_out(pedges)
  );
  // System clock
  initial begin
    forever #2 clk = ~clk;
  end
  // Advance n edges, then drive just after
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Count and report one comparison
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // Control load
  task automatic setup(input logic e, input logic m, input logic p, input logic h);
    en = e;
    mst = m;
    pol = p;
    pha = h;
    ctl_wr = 1'b1;
    step(1);
    ctl_wr = 1'b0;
    step(2);
  endtask
  // Status read and clear check
  task automatic status_clear();
    st_rd = 1'b1;
    step(1);
    st_rd = 1'b0;
    step(2);
    check(status === 8'h00, "flags not cleared by read");
  endtask
  // Bounded wait for the end of a transfer
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      step(1);
      n++;
    end
    check(n < 2000, "busy stuck");
  endtask
  // Expected receive bytes, overflow drops the newest
  task automatic push_exp(input logic [7:0] b);
    if (exp_q.size() < FIFO_DEPTH) exp_q.push_back(b);
  endtask
  // Master byte, optional write during the transfer
  task automatic master_xfer(input logic [7:0] bo, input logic [7:0] bi,
                             input logic p, input logic coll);
    int n;
    ptx = bi;
    psel_n = 1'b0;
    step(1);
    check(sck_w === p, "sck idle level");
    txd = bo;
    tx_wr = 1'b1;
    step(1);
    tx_wr = 1'b0;
    n = 0;
    while (sck_w === p && n < 50) begin
      step(1);
      n++;
    end
    n = 0;
    while (sck_w !== p && n < 50) begin
      step(1);
      n++;
    end
    check(n == DIV, "sck half period");
    check(mosi_oe === 1'b1 && miso_oe === 1'b0, "master pin directions");
    if (coll) begin
      txd = ~bo;
      tx_wr = 1'b1;
      step(1);
      tx_wr = 1'b0;
    end
    wait_idle();
    step(2);
    check(prx === bo, "byte seen by slave");
    check(pedges == 2 * BYTE_BITS, "sck edge count");
    check(sck_w === p, "sck back to idle");
    check(status === {1'b1, coll, 6'h00}, "status after byte");
    psel_n = 1'b1;
    push_exp(bi);
    status_clear();
  endtask
  // Bench acts as external master for a slave byte
  task automatic slave_xfer(input logic [7:0] bo, input logic [7:0] bi,
                            input logic p, input logic h, input logic keep);
    logic [7:0] got;
    txd = bi;
    tx_wr = 1'b1;
    step(1);
    tx_wr = 1'b0;
    if (ss_n === 1'b1) check(miso_oe === 1'b0, "miso floats unselected");
    ss_n = 1'b0;
    step(HP);
    check(miso_oe === 1'b1 && mosi_oe === 1'b0 && sck_oe === 1'b0, "slave pins");
    for (int i = 7; i >= 0; i--) begin
      if (!h) mosi_tb = bo[i];
      step(HP);
      sck_tb = ~p;
      if (h) mosi_tb = bo[i];
      else got[i] = miso_w;
      step(HP);
      sck_tb = p;
      if (h) got[i] = miso_w;
    end
    step(HP);
    if (!keep) ss_n = 1'b1;
    step(8);
    check(got === bi, "byte sent by slave");
    check(status === 8'h80, "slave done flag");
    push_exp(bo);
    status_clear();
  endtask
  // Empty the receive stream and compare in order
  task automatic drain();
    int n;
    n = 0;
    rx_rdy = 1'b1;
    while (rxv === 1'b1 && n < 20) begin
      check(exp_q.size() > 0 && rxd === exp_q[0], "received byte");
      if (exp_q.size() > 0) exp_q.pop_front();
      step(1);
      n++;
    end
    rx_rdy = 1'b0;
    check(exp_q.size() == 0, "received byte count");
  endtask
  // Master with select pulled low
  task automatic mode_fault();
    ss_n = 1'b0;
    step(8);
    check(status === 8'h10 && en_o === 1'b0 && mst_o === 1'b0, "mode fault");
    check(mosi_oe === 1'b0 && miso_oe === 1'b0 && sck_oe === 1'b0, "pins float");
    ss_n = 1'b1;
    status_clear();
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run time
  initial begin
    #200000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
  // Main sequence
  initial begin
    step(16);
    srst = 1'b0;
    step(1);
    check(status === 8'h00 && en_o === 1'b0 && mst_o === 1'b0, "reset state");
    check(mosi_oe === 1'b0 && miso_oe === 1'b0 && sck_oe === 1'b0, "reset pins");
    div = 16'(DIV);
    brg_wr = 1'b1;
    step(1);
    brg_wr = 1'b0;
    for (int m = 0; m < 9; m++) begin
      setup(1'b1, 1'b1, m[1], m[0]);
      master_xfer(8'(8'hb1 << m), 8'(8'h96 >> m), m[1], m == 8);
    end
    drain();
    mode_fault();
    for (int m = 0; m < 4; m++) begin
      sck_tb = m[1];
      setup(1'b1, 1'b0, m[1], m[0]);
      slave_xfer(8'(8'hc3 + m), 8'(8'h5e - m), m[1], m[0], 1'b0);
    end
    slave_xfer(8'h0f, 8'he1, 1'b1, 1'b1, 1'b1);
    slave_xfer(8'h72, 8'h2d, 1'b1, 1'b1, 1'b0);
    drain();
    complete_run();
  end
endmodule
